//--- bench/ejsr_host.sv
`timescale 1ns/1ps
module ejsr_host
  import ejsr_pkg::*;
(
  input  wire logic        mclk,
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ----------
  // System side bus master
  // ----------
  ejsr_avm_t bus = '0;

  assign avs_address   = bus.address;
  assign avs_read      = bus.read;
  assign avs_write     = bus.write;
  assign avs_writedata = bus.writedata;

  // Entered just after a rising edge; assumes no fixed latency
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    bus <= '{address: a, read: !w, write: w, writedata: d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    r = avs_readdata;
    bus <= '0;
    // Idle edge, so a new request never shares the release time step
    @(posedge mclk);
  endtask
endmodule

//--- bench/tb_ejsr_top.sv
`timescale 1ns/1ps
module tb_ejsr_top;
  import ejsr_pkg::*;
  // ----------
  // Bench with reference model
  // ----------
  logic        mclk;
  logic        nrst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  q;
  logic [31:0] rd;
  logic [31:0] d;
  int          n_mismatch;
  int          cmp_count;
  int          mq;
  int          mctl;
  int          mdat;
  int          c;
  int          seq[12] = '{'h31, 'h35, 'h3d, 'h39, 'h3d, 'h3c, 'h30, 'h34, 'h35, 'h31, 'h35, 'h3d};

  ejsr_top ejsr_top_i (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
                       .avs_readdata, .avs_waitrequest, .q);
  ejsr_host ejsr_host_i (.mclk, .avs_address, .avs_read, .avs_write, .avs_writedata,
                         .avs_readdata, .avs_waitrequest);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Model steps on a rise of the OR of both clock bits, as the core sees it
  task automatic wctl(input int v);
    int rise;
    rise = !(mctl[2] | mctl[3]) && (v[2] | v[3]);
    if (!v[0]) mq = 0;
    else if (rise && !v[1]) mq = mdat;
    else if (rise) mq = ((mq << 1) & 'hfe) | ((v[4] & ~mq[0]) | (v[5] & mq[0]));
    mctl = v;
    ejsr_host_i.acc(1'b1, EJSR_ADDR_CTRL, 32'(v), rd);
  endtask

  task automatic chkq();
    ejsr_host_i.acc(1'b0, EJSR_ADDR_STAT, 32'h0, rd);
    chk(rd, mq);
    chk({24'h0, q}, mq);
  endtask

  initial begin
    nrst = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    mq = 0;
    mctl = 'h3d;
    mdat = 0;
    void'($urandom(32'h5eebd083));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk({24'h0, q}, 32'h0);
    ejsr_host_i.acc(1'b0, EJSR_ADDR_CTRL, 32'h0, rd);
    chk(rd, 32'h3d);
    ejsr_host_i.acc(1'b1, 4'hc, 32'hffff_ffff, rd);
    ejsr_host_i.acc(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h0);
    // Every J/inverted-K pair, random load or shift, both clock inputs
    for (int i = 0; i < 48; i++) begin
      d = $urandom;
      mdat = d[7:0];
      ejsr_host_i.acc(1'b1, EJSR_ADDR_DATA, d, rd);
      c = {i[1:0], 3'b000, 1'b1} | (($urandom & 1) << 1);
      wctl(c);
      wctl(c | (i[2] ? 'h4 : 'h8));
      chkq();
    end
    // Inhibit raised only while the other clock is high, then clear
    mdat = 'h5a;
    ejsr_host_i.acc(1'b1, EJSR_ADDR_DATA, 32'ha5a5_005a, rd);
    foreach (seq[k]) begin
      wctl(seq[k]);
      chkq();
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule

//--- rtl/ejsr_core.sv
`timescale 1ns/1ps
module ejsr_core
  import ejsr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       clr_n,
  input  ejsr_pkg::ejsr_ctl_t ctl,
  input  wire logic [7:0] par_in,
  output logic [7:0]      q
);
  import ejsr_pkg::*;

  typedef struct packed {
    logic       clk_seen;
    logic [7:0] stage;
  } ejsr_core_st_t;

  ejsr_core_st_t st;
  ejsr_core_st_t next_st;
  ejsr_mode_t    mode;
  logic          gated_clk;
  logic          rise;
  logic          first;

  // ---------------------------------------------------------------
  // Clock gating and mode
  // ---------------------------------------------------------------
  // Either input high blocks the clock; both inputs treated alike
  assign gated_clk = ctl.clk_a | ctl.clk_b;
  assign rise      = ~st.clk_seen & gated_clk;

  always_comb begin
    if (!rise) begin
      mode = EJSR_INHIBIT;
    end else if (!ctl.load_n) begin
      mode = EJSR_LOAD;
    end else begin
      mode = EJSR_SHIFT;
    end
  end

  // J with inverted K: hold, reset, set or toggle
  always_comb begin
    case ({ctl.j, ctl.k_n})
      2'h1:    first = st.stage[0];
      2'h0:    first = 1'b0;
      2'h3:    first = 1'b1;
      2'h2:    first = ~st.stage[0];
      default: first = st.stage[0];
    endcase
  end

  // ---------------------------------------------------------------
  // Stage update
  // ---------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.clk_seen = gated_clk;
    case (mode)
      EJSR_LOAD:  next_st.stage = par_in;
      EJSR_SHIFT: next_st.stage = {st.stage[6:0], first};
      default:    next_st.stage = st.stage;
    endcase
    if (!clr_n) begin
      next_st.stage = EJSR_CLEARED;
    end
  end

  // Clear is combined with reset so it acts without a clock edge
  // Edge tracker restarts seen-high: no false rise on release of either
  // Limitation: a rise landing with the clear release is not counted
  always_ff @(posedge mclk or negedge nrst or negedge clr_n) begin
    if (!nrst || !clr_n) begin
      st <= '{clk_seen: 1'b1, stage: EJSR_CLEARED};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stage;

  a_clear_zero : assert property (@(posedge mclk) disable iff (!nrst)
    !clr_n |-> q == EJSR_CLEARED) else $error("Clear did not zero stages");
  a_hold_inhibit : assert property (@(posedge mclk) disable iff (!nrst || !clr_n)
    (mode == EJSR_INHIBIT) |=> q == $past(q)) else $error("Stages moved while inhibited");
  a_load_capture : assert property (@(posedge mclk) disable iff (!nrst || !clr_n)
    (mode == EJSR_LOAD) |=> q == $past(par_in)) else $error("Load lost data");
  a_shift_move : assert property (@(posedge mclk) disable iff (!nrst || !clr_n)
    (mode == EJSR_SHIFT) |=> q[7:1] == $past(q[6:0])) else $error("Shift wrong");
  a_jk_set : assert property (@(posedge mclk) disable iff (!nrst || !clr_n)
    (mode == EJSR_SHIFT && ctl.j && ctl.k_n) |=> q[0]) else $error("J-K set failed");
  a_jk_toggle : assert property (@(posedge mclk) disable iff (!nrst || !clr_n)
    (mode == EJSR_SHIFT && ctl.j && !ctl.k_n) |=> q[0] != $past(q[0]))
    else $error("J-K toggle failed");
  a_gate_block : assert property (@(posedge mclk) disable iff (!nrst)
    (ctl.clk_a && ctl.clk_b) |-> mode == EJSR_INHIBIT) else $error("Gated edge leaked");
  a_mode_on_edge : assert property (@(posedge mclk) disable iff (!nrst)
    (mode != EJSR_INHIBIT) |-> $rose(gated_clk)) else $error("Mode without clock rise");

endmodule

//--- rtl/ejsr_pkg.sv
package ejsr_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int          EJSR_WIDTH    = 8;
  localparam logic [7:0]  EJSR_CLEARED  = 8'h00;
  localparam logic [2:0]  EJSR_SYNC_RST = 3'h0;

  // ---------------------------------------------------------------
  // Avalon-MM register map (word offsets are byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  EJSR_ADDR_CTRL  = 4'h0;
  localparam logic [3:0]  EJSR_ADDR_DATA  = 4'h4;
  localparam logic [3:0]  EJSR_ADDR_STAT  = 4'h8;
  localparam int          EJSR_CTRL_CLR   = 0;
  localparam int          EJSR_CTRL_LOAD  = 1;
  localparam int          EJSR_CTRL_CKA   = 2;
  localparam int          EJSR_CTRL_CKB   = 3;
  localparam int          EJSR_CTRL_J     = 4;
  localparam int          EJSR_CTRL_KN    = 5;
  localparam logic [5:0]  EJSR_CTRL_RST   = 6'h3d;

  // ---------------------------------------------------------------
  // Modes, Gray coded
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EJSR_INHIBIT = 2'h0,
    EJSR_SHIFT   = 2'h1,
    EJSR_LOAD    = 2'h3
  } ejsr_mode_t;

  typedef struct packed {
    logic       load_n;
    logic       clk_a;
    logic       clk_b;
    logic       j;
    logic       k_n;
  } ejsr_ctl_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ejsr_avm_t;

endpackage

//--- rtl/ejsr_top.sv
// Behaviour
// - The register has eight stages and works in exactly one of load, shift or inhibit.
// - With load select low and clocking allowed, a rising edge captures all eight data bits.
// - During a load the serial J and inverted-K inputs are ignored.
// - With load select high and clocking allowed, each rising edge shifts first toward last.
// - In shift the first stage holds, clears, sets or toggles from J and inverted K.
// - Both clock inputs are alike; either high inhibits, edges on the other are then ignored.
// - While the clock is inhibited every stage keeps its value whatever the inputs other than the direct clear.
// - A direct clear overrides all modes and zeros the outputs without a clock edge.
`timescale 1ns/1ps
module ejsr_top
  import ejsr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [7:0]       q
);
  import ejsr_pkg::*;

  typedef struct packed {
    logic        done;
    logic [5:0]  ctrl;
    logic [7:0]  data;
    logic [31:0] rdata;
  } ejsr_top_st_t;

  ejsr_top_st_t st;
  ejsr_top_st_t next_st;
  ejsr_ctl_t    ctl;
  ejsr_avm_t    bus;
  logic         req;

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ---------------------------------------------------------------
  assign bus = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  assign req = bus.read | bus.write;
  assign avs_waitrequest = req & ~st.done;
  assign avs_readdata    = st.rdata;

  always_comb begin
    next_st      = st;
    next_st.done = req & ~st.done;
    // Writes land only on the accepting edge, never in the wait state
    if (req && st.done && bus.write) begin
      case (bus.address)
        EJSR_ADDR_CTRL: next_st.ctrl = bus.writedata[5:0];
        EJSR_ADDR_DATA: next_st.data = bus.writedata[7:0];
        default:        next_st.ctrl = st.ctrl;
      endcase
    end
    if (req && !st.done) begin
      if (bus.write) begin
        next_st.rdata = '0;
      end else begin
        case (bus.address)
          EJSR_ADDR_CTRL: next_st.rdata = {26'h0, st.ctrl};
          EJSR_ADDR_DATA: next_st.rdata = {24'h0, st.data};
          EJSR_ADDR_STAT: next_st.rdata = {24'h0, q};
          default:        next_st.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '{done: 1'b0, ctrl: EJSR_CTRL_RST, data: EJSR_CLEARED, rdata: 32'h0};
    end else begin
      st <= next_st;
    end
  end

  // Software writes both clock bits in one word, so glitches cannot arise
  assign ctl = '{load_n: st.ctrl[EJSR_CTRL_LOAD], clk_a: st.ctrl[EJSR_CTRL_CKA],
                 clk_b: st.ctrl[EJSR_CTRL_CKB], j: st.ctrl[EJSR_CTRL_J],
                 k_n: st.ctrl[EJSR_CTRL_KN]};

  ejsr_core ejsr_core_i (
    .mclk   (mclk),
    .nrst   (nrst),
    .clr_n  (st.ctrl[EJSR_CTRL_CLR]),
    .ctl    (ctl),
    .par_in (st.data),
    .q      (q)
  );

  a_bus_answer : assert property (@(posedge mclk) disable iff (!nrst)
    (req && !st.done) |=> !avs_waitrequest || !req) else $error("Slave stalled");

endmodule
